// >>> hw/tec_pkg.sv
// ==========================================
// shared constants and types
`default_nettype none
package tec_pkg;

  localparam int CNT_W = 32;
  localparam int N_CH  = 4;
  localparam int N_PIN = 4;

  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
  localparam logic             EXT_RST = 1'h0;

  typedef enum logic [1:0] {
    TEC_MODE_TIMER = 2'h0,
    TEC_MODE_RISE  = 2'h1,
    TEC_MODE_FALL  = 2'h2,
    TEC_MODE_BOTH  = 2'h3
  } tec_mode_e;

  typedef enum logic [1:0] {
    TEC_EXT_KEEP   = 2'h0,
    TEC_EXT_LOW    = 2'h1,
    TEC_EXT_HIGH   = 2'h2,
    TEC_EXT_TOGGLE = 2'h3
  } tec_ext_e;

  // gray along idle -> run -> halt
  typedef enum logic [1:0] {
    TEC_ST_IDLE = 2'h0,
    TEC_ST_RUN  = 2'h1,
    TEC_ST_HALT = 2'h3
  } tec_run_e;

endpackage : tec_pkg
`default_nettype wire

// >>> hw/tec_match_unit.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// one match channel: compare and output action
module tec_match_unit #(
  parameter int W = tec_pkg::CNT_W
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // compare
  input  wire logic [W-1:0] cnt,
  input  wire logic [W-1:0] mr,
  input  wire logic         step,
  input  wire logic [1:0]   act,
  // results
  output logic              hit,
  output logic              ext_r
);

  logic ext_nxt;

  assign hit = step && (cnt == mr);

  always_comb begin
    ext_nxt = ext_r;
    if (hit) begin
      case (tec_pkg::tec_ext_e'(act))
        tec_pkg::TEC_EXT_LOW:    ext_nxt = 1'h0;
        tec_pkg::TEC_EXT_HIGH:   ext_nxt = 1'h1;
        tec_pkg::TEC_EXT_TOGGLE: ext_nxt = ~ext_r;
        default:                 ext_nxt = ext_r;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) ext_r <= tec_pkg::EXT_RST;
    else       ext_r <= ext_nxt;
  end

  // ==========================================
  // checks
  a_ext_toggle: assert property (@(posedge mclk) disable iff (!rstn)
    hit && act == tec_pkg::TEC_EXT_TOGGLE |=> ext_r != $past(ext_r))
    else $error("match output did not toggle");
  a_ext_hold: assert property (@(posedge mclk) disable iff (!rstn)
    !hit || act == tec_pkg::TEC_EXT_KEEP |=> $stable(ext_r))
    else $error("match output moved without action");

endmodule : tec_match_unit
`default_nettype wire

// >>> hw/tec_capture_unit.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// one capture channel: edge detect and snapshot
module tec_capture_unit #(
  parameter int W = tec_pkg::CNT_W
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // input and config
  input  wire logic         sig,
  input  wire logic         rise_en,
  input  wire logic         fall_en,
  input  wire logic [W-1:0] cnt,
  // results
  output logic              rise_p,
  output logic              fall_p,
  output logic              evt,
  output logic [W-1:0]      cap_r
);

  logic prev_r;

  // one sample per clock; faster input loses edges
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) prev_r <= 1'h0;
    else       prev_r <= sig;
  end

  assign rise_p = sig && !prev_r;
  assign fall_p = !sig && prev_r;
  assign evt    = (rise_p && rise_en) || (fall_p && fall_en);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)    cap_r <= W'(tec_pkg::CNT_RST);
    else if (evt) cap_r <= cnt;
  end

  // ==========================================
  // checks
  a_cap_snap: assert property (@(posedge mclk) disable iff (!rstn)
    evt |=> cap_r == $past(cnt))
    else $error("capture value not the count");

endmodule : tec_capture_unit
`default_nettype wire

// >>> hw/tec_top.sv
`timescale 1ns/1ps
`default_nettype none
module tec_top #(
  parameter int CNT_W = tec_pkg::CNT_W,
  parameter int N_CH  = tec_pkg::N_CH,
  parameter int N_PIN = tec_pkg::N_PIN,
  parameter int SEL_W = $clog2(tec_pkg::N_CH)
) (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  // counter control
  input  wire logic                        cnt_en,
  input  wire logic                        cnt_clr,
  input  wire logic [1:0]                  cnt_mode,
  input  wire logic [SEL_W-1:0]            src_sel,
  input  wire logic [CNT_W-1:0]            presc_limit,
  // match configuration
  input  wire logic [N_CH-1:0][CNT_W-1:0]  match_val,
  input  wire logic [N_CH-1:0]             match_irq_en,
  input  wire logic [N_CH-1:0]             match_stop_en,
  input  wire logic [N_CH-1:0]             match_rst_en,
  input  wire logic [N_CH-1:0][1:0]        ext_act,
  // capture configuration
  input  wire logic [N_CH-1:0]             cap_rise_en,
  input  wire logic [N_CH-1:0]             cap_fall_en,
  input  wire logic [N_CH-1:0]             cap_irq_en,
  input  wire logic [N_CH-1:0][N_PIN-1:0]  cap_route,
  input  wire logic [N_CH-1:0]             cap_and,
  // match pin routing
  input  wire logic [N_PIN-1:0][N_CH-1:0]  mat_route,
  input  wire logic [N_PIN-1:0]            mat_and,
  // pins
  input  wire logic [N_PIN-1:0]            cap_pin,
  output logic      [N_PIN-1:0]            mat_pin_r,
  // interrupt flags
  input  wire logic [2*N_CH-1:0]           irq_clr,
  output logic      [2*N_CH-1:0]           irq_flags_r,
  output logic                             irq_r,
  // status
  output logic      [CNT_W-1:0]            count_r,
  output logic      [CNT_W-1:0]            presc_r,
  output logic      [N_CH-1:0][CNT_W-1:0]  cap_val,
  output logic      [N_CH-1:0]             ext_match,
  output logic      [1:0]                  run_state
);

  // ==========================================
  // elaboration checks
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_w
    $error("CNT_W must be 2..32");
  end
  if (N_CH < 2 || N_PIN < 1 || SEL_W != $clog2(N_CH)) begin : g_bad_n
    $error("N_CH, N_PIN or SEL_W out of range");
  end

  // ==========================================
  // declarations
  tec_pkg::tec_run_e      state_r, state_nxt;
  logic [N_CH-1:0]        ch_sig;
  logic [N_CH-1:0]        rise_p, fall_p, cap_evt;
  logic [N_CH-1:0]        hit;
  logic                   src_evt, tick, step, at_lim;
  logic                   any_stop, any_rst;
  logic [2*N_CH-1:0]      flags_nxt;
  logic [N_PIN-1:0]       mat_pin_nxt;
  logic                   running;

  assign running   = (state_r == tec_pkg::TEC_ST_RUN);
  assign run_state = state_r;

  // ==========================================
  // capture routing and channels
  for (genvar i = 0; i < N_CH; i++) begin : g_cap
    assign ch_sig[i] = cap_and[i]
      ? ((&(cap_pin | ~cap_route[i])) && (|cap_route[i]))
      : (|(cap_pin & cap_route[i]));

    tec_capture_unit #(.W(CNT_W)) u_tec_capture_unit (
      .mclk    (mclk),
      .rstn    (rstn),
      .sig     (ch_sig[i]),
      .rise_en (cap_rise_en[i]),
      .fall_en (cap_fall_en[i]),
      .cnt     (count_r),
      .rise_p  (rise_p[i]),
      .fall_p  (fall_p[i]),
      .evt     (cap_evt[i]),
      .cap_r   (cap_val[i])
    );
  end

  // ==========================================
  // count source
  // every clock in timer mode, else one selected input as event clock
  always_comb begin
    case (tec_pkg::tec_mode_e'(cnt_mode))
      tec_pkg::TEC_MODE_TIMER: src_evt = 1'h1;
      tec_pkg::TEC_MODE_RISE:  src_evt = rise_p[src_sel];
      tec_pkg::TEC_MODE_FALL:  src_evt = fall_p[src_sel];
      tec_pkg::TEC_MODE_BOTH:  src_evt = rise_p[src_sel] || fall_p[src_sel];
      default:                 src_evt = 1'h0;
    endcase
  end

  assign tick   = running && src_evt;
  // a limit lowered below the count wraps at once
  assign at_lim = (presc_r >= presc_limit);
  assign step   = tick && at_lim;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)        presc_r <= CNT_W'(tec_pkg::CNT_RST);
    else if (cnt_clr) presc_r <= CNT_W'(tec_pkg::CNT_RST);
    else if (tick)    presc_r <= at_lim ? CNT_W'(tec_pkg::CNT_RST) : presc_r + 1'h1;
  end

  // ==========================================
  // match channels
  for (genvar i = 0; i < N_CH; i++) begin : g_mat
    tec_match_unit #(.W(CNT_W)) u_tec_match_unit (
      .mclk  (mclk),
      .rstn  (rstn),
      .cnt   (count_r),
      .mr    (match_val[i]),
      .step  (step),
      .act   (ext_act[i]),
      .hit   (hit[i]),
      .ext_r (ext_match[i])
    );
  end

  assign any_stop = |(hit & match_stop_en);
  assign any_rst  = |(hit & match_rst_en);

  // ==========================================
  // main counter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count_r <= CNT_W'(tec_pkg::CNT_RST);
    end else if (cnt_clr) begin
      count_r <= CNT_W'(tec_pkg::CNT_RST);
    end else if (any_rst) begin
      count_r <= CNT_W'(tec_pkg::CNT_RST);
    end else if (any_stop) begin
      count_r <= count_r;
    end else if (step) begin
      count_r <= count_r + 1'h1;
    end
  end

  // ==========================================
  // run control
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tec_pkg::TEC_ST_IDLE: if (cnt_en) state_nxt = tec_pkg::TEC_ST_RUN;
      tec_pkg::TEC_ST_RUN: begin
        if (!cnt_en)       state_nxt = tec_pkg::TEC_ST_IDLE;
        else if (any_stop) state_nxt = tec_pkg::TEC_ST_HALT;
      end
      tec_pkg::TEC_ST_HALT: if (!cnt_en) state_nxt = tec_pkg::TEC_ST_IDLE;
      default: state_nxt = tec_pkg::TEC_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) state_r <= tec_pkg::TEC_ST_IDLE;
    else       state_r <= state_nxt;
  end

  // ==========================================
  // interrupt flags
  // match flag, set wins over clear
  always_comb begin
    flags_nxt = irq_flags_r & ~irq_clr;
    flags_nxt[N_CH-1:0]      = flags_nxt[N_CH-1:0] | (hit & match_irq_en);
    flags_nxt[2*N_CH-1:N_CH] = flags_nxt[2*N_CH-1:N_CH] | (cap_evt & cap_irq_en);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) irq_flags_r <= '0;
    else       irq_flags_r <= flags_nxt;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) irq_r <= 1'h0;
    else       irq_r <= |flags_nxt;
  end

  // ==========================================
  // match pin routing
  // broadcast, OR or AND onto pins
  always_comb begin
    for (int p = 0; p < N_PIN; p++) begin
      mat_pin_nxt[p] = mat_and[p]
        ? ((&(ext_match | ~mat_route[p])) && (|mat_route[p]))
        : (|(ext_match & mat_route[p]));
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) mat_pin_r <= '0;
    else       mat_pin_r <= mat_pin_nxt;
  end

  // ==========================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_timer_tick: assert property (
    running && cnt_mode == tec_pkg::TEC_MODE_TIMER && presc_limit == '0 |-> step)
    else $error("timer mode did not step");
  a_event_gate: assert property (
    cnt_mode != tec_pkg::TEC_MODE_TIMER && !(rise_p[src_sel] || fall_p[src_sel]) |-> !step)
    else $error("counter stepped without event");
  a_presc_wrap: assert property (
    step && !cnt_clr |=> presc_r == '0)
    else $error("prescaler did not wrap");
  a_presc_count: assert property (
    tick && !at_lim && !cnt_clr |=> presc_r == $past(presc_r) + 1'h1)
    else $error("prescaler did not advance");
  a_count_incr: assert property (
    step && !cnt_clr && !any_stop && !any_rst |=> count_r == $past(count_r) + 1'h1)
    else $error("counter did not increment");
  a_count_idle: assert property (
    !running && !cnt_clr |=> $stable(count_r))
    else $error("counter moved while not running");
  a_stop_halt: assert property (
    any_stop && !any_rst && !cnt_clr && cnt_en
      |=> state_r == tec_pkg::TEC_ST_HALT && $stable(count_r) ##1 $stable(count_r))
    else $error("stop match did not halt");
  a_reset_zero: assert property (
    any_rst && !cnt_clr |=> count_r == '0)
    else $error("reset match did not clear count");
  a_run_through: assert property (
    step && !any_stop && cnt_en |=> state_r == tec_pkg::TEC_ST_RUN)
    else $error("continuous match left run state");
  a_match_flag: assert property (
    hit[0] && match_irq_en[0] |=> irq_flags_r[0] && irq_r)
    else $error("match flag or line not raised");
  a_cap_flag: assert property (
    cap_evt[1] && cap_irq_en[1] |=> irq_flags_r[N_CH+1] && irq_r)
    else $error("capture flag not raised");
  a_irq_line: assert property (
    irq_r == (|irq_flags_r))
    else $error("interrupt line disagrees with flags");
  a_route_or: assert property (
    !cap_and[0] && |(cap_pin & cap_route[0]) |-> ch_sig[0])
    else $error("capture OR routing failed");
  a_clr_zero: assert property (
    cnt_clr |=> count_r == '0 && presc_r == '0)
    else $error("clear did not zero the counters");
  a_presc_idle: assert property (
    !tick && !cnt_clr |=> $stable(presc_r))
    else $error("prescaler moved without a tick");
  a_fall_gate: assert property (
    running && cnt_mode == tec_pkg::TEC_MODE_FALL && rise_p[src_sel] |-> !step)
    else $error("falling mode stepped on a rise");
  a_halt_hold: assert property (
    state_r == tec_pkg::TEC_ST_HALT && cnt_en && !cnt_clr
      |=> state_r == tec_pkg::TEC_ST_HALT && $stable(count_r))
    else $error("halted counter resumed");
  a_irq_hold: assert property (
    (|(irq_flags_r & ~irq_clr)) |=> irq_r)
    else $error("pending flag lost from interrupt line");
  a_cap_idle: assert property (
    !cap_evt[0] |=> $stable(cap_val[0]))
    else $error("capture value moved without an event");
  a_pin_follow: assert property (
    !mat_and[0] |=> mat_pin_r[0] == $past(|(ext_match & mat_route[0])))
    else $error("match pin did not follow OR routing");

  c_stop:  cover property (any_stop ##1 state_r == tec_pkg::TEC_ST_HALT);
  c_reset: cover property (any_rst ##1 count_r == '0);
  c_event: cover property (cnt_mode != tec_pkg::TEC_MODE_TIMER && step);
  c_cap:   cover property (cap_evt[2] && running);
  c_both:  cover property (cnt_mode == tec_pkg::TEC_MODE_BOTH && fall_p[src_sel] && step);

endmodule : tec_top
`default_nettype wire

// >>> sim/tec_evt_src.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// far side: edge source on the capture pins
module tec_evt_src (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // per-pin toggle enable
  input  wire logic [3:0] en,
  // pins, idle low
  output logic      [3:0] pin_r
);
  logic ph_r;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ph_r  <= 1'h0;
      pin_r <= 4'h0;
    end else begin
      ph_r <= ~ph_r;
      if (ph_r) begin
        pin_r <= pin_r ^ en;
      end
    end
  end
endmodule : tec_evt_src
`default_nettype wire

// >>> sim/tec_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
// ==========================================
// self-checking bench
module tec_top_tb_top;
  logic              mclk = 1'h0;
  logic              rstn = 1'h0;
  logic              cnt_en = 1'h0;
  logic              cnt_clr = 1'h0;
  logic [1:0]        cnt_mode = 2'h0;
  logic [1:0]        src_sel = 2'h0;
  logic [31:0]       presc_limit = 32'h0;
  logic [3:0][31:0]  match_val = '0;
  logic [3:0]        match_irq_en = 4'h0;
  logic [3:0]        match_stop_en = 4'h0;
  logic [3:0]        match_rst_en = 4'h0;
  logic [3:0][1:0]   ext_act = '0;
  logic [3:0]        cap_rise_en = 4'h0;
  logic [3:0]        cap_fall_en = 4'h0;
  logic [3:0]        cap_irq_en = 4'h0;
  logic [3:0][3:0]   cap_route = {4'h3, 4'h3, 4'h4, 4'h1};
  logic [3:0]        cap_and = 4'h4;
  logic [3:0][3:0]   mat_route = {4'h0, 4'h0, 4'h3, 4'h1};
  logic [3:0]        mat_and = 4'h2;
  logic [3:0]        src_en = 4'h0;
  logic [3:0]        cap_pin;
  logic [7:0]        irq_clr = 8'h0;
  logic [3:0]        mat_pin_r;
  logic [7:0]        irq_flags_r;
  logic              irq_r;
  logic [31:0]       count_r;
  logic [31:0]       presc_r;
  logic [3:0][31:0]  cap_val;
  logic [3:0]        ext_match;
  logic [1:0]        run_state;
  int                num_errors = 0;
  int                tests_run = 0;
  int                n;
  int                rise_n = 0;
  int                fall_n = 0;
  logic              counting = 1'h0;

  always #20 mclk = ~mclk;

  tec_top u_tec_top (.mclk(mclk), .rstn(rstn), .cnt_en(cnt_en), .cnt_clr(cnt_clr), .cnt_mode(cnt_mode),
    .src_sel(src_sel), .presc_limit(presc_limit), .match_val(match_val), .match_irq_en(match_irq_en),
    .match_stop_en(match_stop_en), .match_rst_en(match_rst_en), .ext_act(ext_act), .cap_rise_en(cap_rise_en),
    .cap_fall_en(cap_fall_en), .cap_irq_en(cap_irq_en), .cap_route(cap_route), .cap_and(cap_and),
    .mat_route(mat_route), .mat_and(mat_and), .cap_pin(cap_pin), .mat_pin_r(mat_pin_r), .irq_clr(irq_clr),
    .irq_flags_r(irq_flags_r), .irq_r(irq_r), .count_r(count_r), .presc_r(presc_r), .cap_val(cap_val),
    .ext_match(ext_match), .run_state(run_state));

  tec_evt_src u_tec_evt_src (.mclk(mclk), .rstn(rstn), .en(src_en), .pin_r(cap_pin));

  always @(posedge cap_pin[0]) if (counting) rise_n++;
  always @(negedge cap_pin[0]) if (counting) fall_n++;

  task automatic print_verdict;
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // stop, zero the counters, drop all flags
  task automatic restart;
    @(negedge mclk);
    cnt_en = 1'h0;
    cnt_clr = 1'h1;
    irq_clr = 8'hff;
    @(negedge mclk);
    cnt_clr = 1'h0;
    irq_clr = 8'h0;
    `CHK(count_r, 32'h0)
  endtask : restart

  task automatic wait_until_flag(input int b);
    for (n = 0; n < 200 && irq_flags_r[b] !== 1'h1; n++) @(negedge mclk);
    `CHK(irq_flags_r[b], 1'h1)
  endtask : wait_until_flag

  // toggle source pins for a while in one edge mode
  task automatic run_source(input logic [1:0] mode, input logic [3:0] pins);
    restart();
    cnt_mode = mode;
    cnt_en = 1'h1;
    repeat (2) @(negedge mclk);
    rise_n = 0;
    fall_n = 0;
    counting = 1'h1;
    src_en = pins;
    repeat (40) @(negedge mclk);
    src_en = 4'h0;
    repeat (6) @(negedge mclk);
    counting = 1'h0;
  endtask : run_source

  initial begin
    #(40 * 5000);
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (16) @(negedge mclk);
    rstn = 1'h1;
    // ==========================================
    // prescaler spacing
    presc_limit = 32'h2;
    cnt_en = 1'h1;
    for (n = 0; n < 50 && count_r !== 32'h1; n++) @(negedge mclk);
    `CHK(presc_r, 32'h0)
    n = 0;
    while (count_r === 32'h1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    `CHK(n, 3)
    `CHK(count_r, 32'h2)
    // ==========================================
    // continuous match, toggle, interrupt
    restart();
    presc_limit = 32'h0;
    match_val = {32'h3, 32'h0, 32'h0, 32'h5};
    match_irq_en = 4'h1;
    ext_act = {tec_pkg::TEC_EXT_KEEP, 2'h0, 2'h0, tec_pkg::TEC_EXT_TOGGLE};
    cnt_en = 1'h1;
    wait_until_flag(0);
    `CHK(count_r, 32'h6)
    `CHK(irq_r, 1'h1)
    `CHK(ext_match[0], 1'h1)
    @(negedge mclk);
    `CHK(mat_pin_r[0], 1'h1)
    irq_clr = 8'h1;
    @(negedge mclk);
    irq_clr = 8'h0;
    @(negedge mclk);
    `CHK(irq_r, 1'h0)
    // ==========================================
    // reset on match
    restart();
    match_val[1] = 32'h7;
    match_irq_en = 4'h2;
    match_rst_en = 4'h2;
    ext_act[0] = tec_pkg::TEC_EXT_KEEP;
    ext_act[1] = tec_pkg::TEC_EXT_HIGH;
    cnt_en = 1'h1;
    wait_until_flag(1);
    `CHK(count_r, 32'h0)
    repeat (20) @(negedge mclk);
    `CHK(count_r < 32'h8, 1'h1)
    `CHK(mat_pin_r[1], 1'h1)
    `CHK(ext_match[3], 1'h0)
    // ==========================================
    // stop on match, drive low
    restart();
    match_rst_en = 4'h0;
    match_stop_en = 4'h4;
    match_val[2] = 32'h4;
    match_val[0] = 32'h2;
    ext_act[0] = tec_pkg::TEC_EXT_LOW;
    cnt_en = 1'h1;
    for (n = 0; n < 50 && run_state !== tec_pkg::TEC_ST_HALT; n++) @(negedge mclk);
    `CHK(count_r, 32'h4)
    `CHK(run_state, tec_pkg::TEC_ST_HALT)
    repeat (5) @(negedge mclk);
    `CHK(count_r, 32'h4)
    `CHK(ext_match[0], 1'h0)
    // ==========================================
    // event counting with side captures
    match_stop_en = 4'h0;
    cap_rise_en = 4'hf;
    cap_irq_en = 4'hf;
    run_source(tec_pkg::TEC_MODE_RISE, 4'h5);
    `CHK(count_r, 32'(rise_n))
    `CHK(rise_n > 5, 1'h1)
    `CHK(irq_flags_r[5], 1'h1)
    `CHK(cap_val[1] != 32'h0, 1'h1)
    `CHK(irq_flags_r[6], 1'h0)
    `CHK(irq_flags_r[7], 1'h1)
    run_source(tec_pkg::TEC_MODE_FALL, 4'h5);
    `CHK(count_r, 32'(fall_n))
    `CHK(fall_n > 5, 1'h1)
    run_source(tec_pkg::TEC_MODE_BOTH, 4'h7);
    `CHK(count_r, 32'(rise_n + fall_n))
    `CHK(irq_flags_r[6], 1'h1)
    print_verdict();
  end
endmodule : tec_top_tb_top
`default_nettype wire
